// ---- rtl/ccd_regs.svh ----
// register offsets, field positions and reset values of the clock channel divider
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

`define CCD_ADDR_W 10
`define CCD_IDX_COUNTS 10'h190
`define CCD_IDX_CTRL 10'h191
`define CCD_IDX_STATUS 10'h198

`define CCD_COUNTS_RST 8'h00
`define CCD_CTRL_RST 8'h80

`define CCD_LOW_MSB 7
`define CCD_LOW_LSB 4
`define CCD_HIGH_MSB 3
`define CCD_HIGH_LSB 0

`define CCD_BIT_BYPASS 7
`define CCD_BIT_NOSYNC 6
`define CCD_BIT_FORCE 5
`define CCD_BIT_START 4
`define CCD_PHASE_MSB 3
`define CCD_PHASE_LSB 0

`endif

// ---- rtl/ccd_pkg.sv ----
// types of the clock channel divider
package ccd_pkg;

  typedef struct packed {
    logic [3:0] lowCount;
    logic [3:0] highCount;
  } ccd_counts_t;

  typedef struct packed {
    logic bypass;
    logic noSync;
    logic forceHigh;
    logic startHigh;
    logic [3:0] phase;
  } ccd_ctrl_t;

  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ccd_avs_req_t;

  typedef enum logic [4:0] {
    ST_BYPASS = 5'h01,
    ST_HOLD = 5'h02,
    ST_STATIC = 5'h04,
    ST_PHASE = 5'h08,
    ST_RUN = 5'h10
  } ccd_state_t;

endpackage

// ---- rtl/ccd_clock_channel_divider.sv ----
// clock channel divider with avalon-mm register slave
`timescale 1ns/1ns
`default_nettype none
`include "ccd_regs.svh"

module ccd_clock_channel_divider (
  input wire logic clk,
  input wire logic reset,
  input wire ccd_pkg::ccd_avs_req_t avsReq,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic clkIn,
  input wire logic syncReq,
  output logic divOut
);
  import ccd_pkg::*;

  // ****************************************
  // registers and bus slave
  // ****************************************
  ccd_counts_t countsFf;
  ccd_ctrl_t ctrlFf;
  ccd_state_t stateFf;
  ccd_state_t nxt_state;
  logic [31:0] readDataFf;
  logic waitReqFf;
  logic divOutFf;
  logic levelFf;
  logic [3:0] cntFf;
  logic [3:0] phaseCntFf;
  logic clkInPrevFf;
  logic inEdge;
  logic busReq;
  logic busTake;
  logic [7:0] statusVal;
  logic [7:0] wrByte;

  assign busReq = avsReq.read | avsReq.write;
  assign busTake = busReq & ~waitReqFf;
  assign statusVal = {3'h0, stateFf};
  assign wrByte = avsReq.writedata[7:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      waitReqFf <= 1'b1;
    end else begin
      waitReqFf <= ~(busReq & waitReqFf);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readDataFf <= 32'h0;
    end else if (avsReq.read & waitReqFf) begin
      unique case (avsReq.address)
        `CCD_IDX_COUNTS: readDataFf <= {24'h0, countsFf};
        `CCD_IDX_CTRL: readDataFf <= {24'h0, ctrlFf};
        `CCD_IDX_STATUS: readDataFf <= {24'h0, statusVal};
        default: readDataFf <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      countsFf <= ccd_counts_t'(`CCD_COUNTS_RST);
      ctrlFf <= ccd_ctrl_t'(`CCD_CTRL_RST);
    end else if (busTake & avsReq.write & avsReq.byteenable[0]) begin
      if (avsReq.address == `CCD_IDX_COUNTS) begin
        countsFf.lowCount <= avsReq.writedata[`CCD_LOW_MSB:`CCD_LOW_LSB];
        countsFf.highCount <= avsReq.writedata[`CCD_HIGH_MSB:`CCD_HIGH_LSB];
      end
      if (avsReq.address == `CCD_IDX_CTRL) begin
        ctrlFf.bypass <= avsReq.writedata[`CCD_BIT_BYPASS];
        ctrlFf.noSync <= avsReq.writedata[`CCD_BIT_NOSYNC];
        ctrlFf.forceHigh <= avsReq.writedata[`CCD_BIT_FORCE];
        ctrlFf.startHigh <= avsReq.writedata[`CCD_BIT_START];
        ctrlFf.phase <= avsReq.writedata[`CCD_PHASE_MSB:`CCD_PHASE_LSB];
      end
    end
  end

  // ****************************************
  // divider state
  // ****************************************
  assign inEdge = clkIn & ~clkInPrevFf;

  always_ff @(posedge clk) begin
    if (reset) begin
      clkInPrevFf <= 1'b0;
    end else begin
      clkInPrevFf <= clkIn;
    end
  end

  always_comb begin
    nxt_state = stateFf;
    if (ctrlFf.bypass) begin
      nxt_state = ST_BYPASS;
    end else if (ctrlFf.noSync & ctrlFf.forceHigh) begin
      nxt_state = ST_STATIC;
    end else if (syncReq & ~ctrlFf.noSync) begin
      nxt_state = ST_HOLD;
    end else begin
      unique case (stateFf)
        ST_BYPASS, ST_HOLD, ST_STATIC: nxt_state = ST_PHASE;
        ST_PHASE: if (inEdge && phaseCntFf == 4'h0) nxt_state = ST_RUN;
        ST_RUN: nxt_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stateFf <= ST_BYPASS;
    end else begin
      stateFf <= nxt_state;
    end
  end

  // phase offset before counting starts
  always_ff @(posedge clk) begin
    if (reset) begin
      phaseCntFf <= 4'h0;
    end else if (stateFf != ST_PHASE && nxt_state == ST_PHASE) begin
      phaseCntFf <= ctrlFf.phase;
    end else if (stateFf == ST_PHASE && inEdge && phaseCntFf != 4'h0) begin
      phaseCntFf <= phaseCntFf - 4'h1;
    end
  end

  // low and high counting
  always_ff @(posedge clk) begin
    if (reset) begin
      levelFf <= 1'b0;
      cntFf <= 4'h0;
    end else if (nxt_state != ST_PHASE && nxt_state != ST_RUN) begin
      levelFf <= 1'b0;
      cntFf <= 4'h0;
    end else if (stateFf != ST_PHASE && nxt_state == ST_PHASE) begin
      levelFf <= ctrlFf.startHigh;
      cntFf <= 4'h0;
    end else if (stateFf == ST_RUN && inEdge) begin
      if (cntFf == (levelFf ? countsFf.highCount : countsFf.lowCount)) begin
        levelFf <= ~levelFf;
        cntFf <= 4'h0;
      end else begin
        cntFf <= cntFf + 4'h1;
      end
    end
  end

  // ****************************************
  // output
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      divOutFf <= 1'b0;
    end else begin
      unique case (stateFf)
        ST_BYPASS: divOutFf <= clkIn;
        ST_HOLD: divOutFf <= 1'b0;
        ST_STATIC: divOutFf <= 1'b1;
        ST_PHASE, ST_RUN: divOutFf <= levelFf;
      endcase
    end
  end

  assign divOut = divOutFf;
  assign readdata = readDataFf;
  assign waitrequest = waitReqFf;

  // ****************************************
  // assertions
  // ****************************************
  property p_low_end;
    @(posedge clk) disable iff (reset)
    (stateFf == ST_RUN && nxt_state == ST_RUN && inEdge && !levelFf
      && cntFf == countsFf.lowCount) |=> levelFf;
  endproperty
  a_low_end: assert property (p_low_end) else $error("low phase did not end");

  property p_low_hold;
    @(posedge clk) disable iff (reset)
    (stateFf == ST_RUN && nxt_state == ST_RUN && !levelFf
      && cntFf != countsFf.lowCount) |=> !levelFf;
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low phase ended early");

  property p_high_end;
    @(posedge clk) disable iff (reset)
    (stateFf == ST_RUN && nxt_state == ST_RUN && inEdge && levelFf
      && cntFf == countsFf.highCount) |=> !levelFf ##1 !divOutFf;
  endproperty
  a_high_end: assert property (p_high_end) else $error("high phase did not end");

  property p_bypass;
    @(posedge clk) disable iff (reset)
    stateFf == ST_BYPASS |=> divOutFf == $past(clkIn) && cntFf == 4'h0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not passing input");

  property p_reset_bypass;
    @(posedge clk) reset |=> ctrlFf.bypass && stateFf == ST_BYPASS;
  endproperty
  a_reset_bypass: assert property (p_reset_bypass) else $error("bypass not set");

  property p_sync_obey;
    @(posedge clk) disable iff (reset)
    (!ctrlFf.bypass && !ctrlFf.noSync && syncReq) |=> stateFf == ST_HOLD ##1 !divOutFf;
  endproperty
  a_sync_obey: assert property (p_sync_obey) else $error("sync request not obeyed");

  property p_sync_ignore;
    @(posedge clk) disable iff (reset)
    (stateFf == ST_RUN && !ctrlFf.bypass && ctrlFf.noSync && !ctrlFf.forceHigh)
      |=> stateFf == ST_RUN;
  endproperty
  a_sync_ignore: assert property (p_sync_ignore) else $error("ignored sync restarted");

  property p_static_high;
    @(posedge clk) disable iff (reset)
    (!ctrlFf.bypass && ctrlFf.noSync && ctrlFf.forceHigh) |=> ##1 divOutFf;
  endproperty
  a_static_high: assert property (p_static_high) else $error("force high not applied");

  property p_bypass_wins;
    @(posedge clk) disable iff (reset)
    (ctrlFf.bypass && ctrlFf.forceHigh) |=> stateFf == ST_BYPASS;
  endproperty
  a_bypass_wins: assert property (p_bypass_wins) else $error("static beat bypass");

  property p_start_level;
    @(posedge clk) disable iff (reset)
    (stateFf != ST_PHASE && nxt_state == ST_PHASE)
      |=> levelFf == $past(ctrlFf.startHigh) && phaseCntFf == $past(ctrlFf.phase);
  endproperty
  a_start_level: assert property (p_start_level) else $error("bad start");

  property p_wait_one;
    @(posedge clk) disable iff (reset)
    (busReq && waitReqFf) |=> !waitReqFf;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer");

  property p_wait_pulse;
    @(posedge clk) disable iff (reset)
    !waitReqFf |=> waitReqFf;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");

  property p_write_counts;
    @(posedge clk) disable iff (reset)
    (busTake && avsReq.write && avsReq.byteenable[0] && avsReq.address == `CCD_IDX_COUNTS)
      |=> countsFf == $past(wrByte);
  endproperty
  a_write_counts: assert property (p_write_counts) else $error("bad counts");

  property p_write_ctrl;
    @(posedge clk) disable iff (reset)
    (busTake && avsReq.write && avsReq.byteenable[0] && avsReq.address == `CCD_IDX_CTRL)
      |=> ctrlFf == $past(wrByte);
  endproperty
  a_write_ctrl: assert property (p_write_ctrl) else $error("bad control");

  property p_masked_write;
    @(posedge clk) disable iff (reset)
    (busTake && avsReq.write && !avsReq.byteenable[0])
      |=> countsFf == $past(countsFf) && ctrlFf == $past(ctrlFf);
  endproperty
  a_masked_write: assert property (p_masked_write) else $error("masked write landed");

  property p_read_ctrl;
    @(posedge clk) disable iff (reset)
    (avsReq.read && waitReqFf && avsReq.address == `CCD_IDX_CTRL)
      |=> readDataFf == {24'h0, $past(ctrlFf)};
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("bad control read");

  property p_read_unmapped;
    @(posedge clk) disable iff (reset)
    (avsReq.read && waitReqFf && avsReq.address != `CCD_IDX_COUNTS
      && avsReq.address != `CCD_IDX_CTRL && avsReq.address != `CCD_IDX_STATUS)
      |=> readDataFf == 32'h0;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_phase_count;
    @(posedge clk) disable iff (reset)
    (stateFf == ST_PHASE && nxt_state == ST_PHASE && inEdge && phaseCntFf != 4'h0)
      |=> phaseCntFf == $past(phaseCntFf) - 4'h1;
  endproperty
  a_phase_count: assert property (p_phase_count) else $error("phase count wrong");

  property p_phase_wait;
    @(posedge clk) disable iff (reset)
    (stateFf == ST_PHASE && phaseCntFf != 4'h0) |=> stateFf != ST_RUN;
  endproperty
  a_phase_wait: assert property (p_phase_wait) else $error("run before phase end");

  property p_hold_low;
    @(posedge clk) disable iff (reset)
    stateFf == ST_HOLD |=> !divOutFf;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("hold not low");

  property p_high_hold;
    @(posedge clk) disable iff (reset)
    (stateFf == ST_RUN && nxt_state == ST_RUN && levelFf
      && cntFf != countsFf.highCount) |=> levelFf;
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high phase ended early");

  property p_run_out;
    @(posedge clk) disable iff (reset)
    stateFf == ST_RUN |=> divOutFf == $past(levelFf);
  endproperty
  a_run_out: assert property (p_run_out) else $error("output not level");

endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking testbench of the clock channel divider
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ccd_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic clkIn = 0;
  logic clkInDly = 0;
  logic syncReq = 0;
  ccd_avs_req_t avsReq = '0;
  logic [3:0] busBe = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic divOut;
  logic [31:0] seed = 32'h4e;
  logic [31:0] q;
  logic [7:0] c;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int hi;
  int lo;
  always #25 clk = ~clk;
  ccd_clock_channel_divider uut (.clk(clk), .reset(reset), .avsReq(avsReq),
    .readdata(readdata), .waitrequest(waitrequest), .clkIn(clkIn), .syncReq(syncReq),
    .divOut(divOut));
  always @(posedge clk) begin
    clkIn <= ~clkIn;
    clkInDly <= clkIn;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(logic wr, logic [9:0] a, logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    avsReq.address <= a;
    avsReq.read <= !wr;
    avsReq.write <= wr;
    avsReq.writedata <= {24'h000000, d};
    avsReq.byteenable <= busBe;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    r = readdata;
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
  endtask
  task automatic rd(string what, logic [9:0] a, logic [7:0] exp);
    bus(1'b0, a, 8'h00, q);
    check(what, {24'h000000, exp}, q);
  endtask
  task automatic follow(string what);
    repeat (8) begin
      @(negedge clk);
      check(what, clkInDly, divOut);
    end
  endtask
  task automatic level(string what, logic exp);
    repeat (8) begin
      @(negedge clk);
      check(what, exp, divOut);
    end
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd("counts reset", 10'h190, 8'h00);
    rd("ctrl reset", 10'h191, 8'h80);
    rd("unmapped", 10'h1a0, 8'h00);
    rd("status bypass", 10'h198, 8'h01);
    follow("bypass out");
    $display("test reset done");
    repeat (4) begin
      seed = xs(seed);
      bus(1'b1, 10'h190, seed[7:0], q);
      rd("counts rw", 10'h190, seed[7:0]);
    end
    busBe = 4'h0;
    bus(1'b1, 10'h190, ~seed[7:0], q);
    busBe = 4'hf;
    rd("masked write", 10'h190, seed[7:0]);
    $display("test register done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      bus(1'b1, 10'h190, c, q);
      bus(1'b1, 10'h191, 8'h40, q);
      repeat (4) @(negedge clk);
      while (divOut !== 1'b0) @(negedge clk);
      while (divOut !== 1'b1) @(negedge clk);
      hi = 0;
      while (divOut === 1'b1) begin
        hi++;
        @(negedge clk);
      end
      lo = 0;
      while (divOut === 1'b0) begin
        lo++;
        @(negedge clk);
      end
      check("high width", (c[3:0] + 1) * 2, hi);
      check("low width", (c[7:4] + 1) * 2, lo);
      check("period", (c[7:4] + c[3:0] + 2) * 2, hi + lo);
    end
    $display("test divide done");
    bus(1'b1, 10'h191, 8'he0, q);
    repeat (2) @(negedge clk);
    follow("force in bypass");
    bus(1'b1, 10'h191, 8'h60, q);
    repeat (2) @(negedge clk);
    level("forced high", 1'b1);
    $display("test force done");
    bus(1'b1, 10'h190, 8'h00, q);
    bus(1'b1, 10'h191, 8'h20, q);
    syncReq <= 1'b1;
    repeat (3) @(negedge clk);
    level("sync hold", 1'b0);
    bus(1'b1, 10'h191, 8'h5f, q);
    repeat (2) @(negedge clk);
    level("start high", 1'b1);
    hi = 0;
    while (divOut === 1'b1) begin
      hi++;
      @(negedge clk);
    end
    check("phase delay", 17, (hi + 8) / 2);
    @(posedge clk);
    syncReq <= 1'b0;
    $display("test sync done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd("ctrl after reset", 10'h191, 8'h80);
    rd("counts after reset", 10'h190, 8'h00);
    rd("status after reset", 10'h198, 8'h01);
    $display("test reset again done");
    complete_run();
  end
endmodule
`default_nettype wire
